// File: rtl/eeprom_pkg.sv
// constants, phase type and check-bit helpers for the serial eeprom slave
// assumes one includer; functions are pure and synthesizable
package eeprom_pkg;

  localparam int BYTE_BITS = 8;
  localparam int WORD_BYTES = 4;
  localparam int ECC_BITS = 6;
  localparam int CODE_BITS = 38;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [5:0] PIN_RST = 6'h30;

  typedef enum {PH_IDLE, PH_SEL, PH_AHI, PH_ALO, PH_WR, PH_RD, PH_BUSY} phase_t;

  // hamming layout: data fills the non power-of-two positions 3..38
  function automatic logic [5:0] ecc_calc(input logic [31:0] d);
    logic [5:0] c;
    int j;
    c = 6'h00;
    j = 0;
    for (int p = 1; p < 39; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        for (int k = 0; k < 6; k++)
          if (p[k])
            c[k] = c[k] ^ d[j];
        j++;
      end
    end
    return c;
  endfunction : ecc_calc

  // word layout is {check, data}; a single flipped data bit is repaired
  function automatic logic [31:0] ecc_fix(input logic [37:0] w);
    logic [5:0] s;
    logic [31:0] d;
    int j;
    s = w[37:32] ^ ecc_calc(w[31:0]);
    d = w[31:0];
    j = 0;
    for (int p = 1; p < 39; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (s == p[5:0])
          d[j] = ~d[j];
        j++;
      end
    end
    return d;
  endfunction : ecc_fix

endpackage : eeprom_pkg

// File: rtl/i2c_serial_eeprom_slave.sv
// two-wire serial eeprom slave with page buffer and check-bit protected array
// assumes scl high and low phases each last at least four core clocks
`timescale 1ns/100ps
`default_nettype none

module i2c_serial_eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int PAGE_W = 7,
  parameter int WRITE_CYCLE_TIME = 5000,
  // type code value is arbitrary
  parameter logic [3:0] DEV_TYPE_ID = 4'h5
)(
  // core clock and control
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  // serial link
  input wire logic SCL_CLK,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // straps
  input wire logic CHIP_SEL_IN0,
  input wire logic CHIP_SEL_IN1,
  input wire logic CHIP_SEL_IN2,
  input wire logic WRITE_PROTECT_IN,
  // status
  output logic WRITE_BUSY
);

  localparam int NWORDS = 2 ** (ADDR_W - 2);
  localparam int ROW_BYTES = 2 ** PAGE_W;
  localparam int ROW_WORDS = ROW_BYTES / WORD_BYTES;
  localparam int WI_W = PAGE_W - 2;
  logic sda_cap_r, sda_q_r, scl_q_r, sda, scl, wp;
  logic [5:0] pin_raw, s1_r, s2_r, s3_r, pin_r;
  logic [2:0] chip_sel;
  logic scl_rise, scl_fall, start_ev, stop_ev, sel_match, commit_en;
  phase_t phase_r;
  logic [3:0] bitcnt_r, wval;
  logic [7:0] shift_r, out_r, rd_byte;
  logic [ADDR_W-1:0] addr_r;
  logic wp_seen_r, armed_r, sda_oe_r, sda_o_r, busy_r;
  logic [31:0] busy_cnt_r, word_rd, old_word, merged;
  logic [CODE_BITS-1:0] mem [NWORDS];
  logic [7:0] pbuf_r [ROW_BYTES];
  logic [ROW_BYTES-1:0] pval_r;
  logic [ADDR_W-PAGE_W-1:0] row_r;
  logic [WI_W-1:0] wi;
  logic [ADDR_W-3:0] waddr;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: data captured at the real scl edge, read later by the core
  // once the synchronised edge arrives, when it has long been stable
  always_ff @(posedge SCL_CLK)
    sda_cap_r <= SDA_I;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  assign pin_raw = {SDA_I, SCL_CLK, WRITE_PROTECT_IN, CHIP_SEL_IN2, CHIP_SEL_IN1, CHIP_SEL_IN0};

  for (genvar g = 0; g < 6; g++)
  begin : g_sync
    always_ff @(posedge CORE_CLK)
    begin
      if (RST)
      begin
        s1_r[g] <= PIN_RST[g];
        s2_r[g] <= PIN_RST[g];
        s3_r[g] <= PIN_RST[g];
        pin_r[g] <= PIN_RST[g];
      end
      else if (CLK_EN)
      begin
        s1_r[g] <= pin_raw[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (s2_r[g] == s3_r[g])
          pin_r[g] <= s3_r[g];
      end
    end
  end

  assign {sda, scl, wp, chip_sel} = pin_r;

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      sda_q_r <= 1'b1;
      scl_q_r <= 1'b1;
    end
    else if (CLK_EN)
    begin
      sda_q_r <= sda;
      scl_q_r <= scl;
    end
  end

  assign scl_rise = scl & ~scl_q_r;
  assign scl_fall = ~scl & scl_q_r;
  assign start_ev = scl & scl_q_r & sda_q_r & ~sda;
  assign stop_ev = scl & scl_q_r & ~sda_q_r & sda;
  assign sel_match = (shift_r[7:4] == DEV_TYPE_ID) && (shift_r[3:1] == chip_sel);

  // read path always corrects through the check bits
  assign word_rd = ecc_fix(mem[addr_r[ADDR_W-1:2]]);
  assign rd_byte = word_rd[8 * addr_r[1:0] +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      phase_r <= PH_IDLE;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      out_r <= 8'h00;
      addr_r <= '0;
      wp_seen_r <= 1'b0;
      armed_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (phase_r == PH_BUSY)
      begin
        // deaf to the bus, so polling selects are never acked
        sda_oe_r <= 1'b0;
        if (busy_cnt_r == WRITE_CYCLE_TIME - 1)
          phase_r <= PH_IDLE;
      end
      else if (start_ev)
      begin
        phase_r <= PH_SEL;
        bitcnt_r <= '1; // the start's own scl fall wraps this to zero
        sda_oe_r <= 1'b0;
        wp_seen_r <= wp;
        armed_r <= 1'b0;
      end
      else if (stop_ev)
      begin
        sda_oe_r <= 1'b0;
        armed_r <= 1'b0;
        if (armed_r && bitcnt_r == 4'h0)
          phase_r <= PH_BUSY;
        else
          phase_r <= PH_IDLE;
      end
      else if (phase_r != PH_IDLE)
      begin
        if (phase_r == PH_SEL || phase_r == PH_AHI || phase_r == PH_ALO)
          wp_seen_r <= wp_seen_r | wp;
        if (scl_rise)
        begin
          if (bitcnt_r != ACK_SLOT)
            shift_r <= {shift_r[6:0], sda_cap_r};
          else if (phase_r == PH_RD)
          begin
            addr_r <= addr_r + 1'b1;
            if (sda_cap_r)
              phase_r <= PH_IDLE;
          end
        end
        if (scl_fall)
        begin
          bitcnt_r <= (bitcnt_r == ACK_SLOT) ? 4'h0 : bitcnt_r + 4'h1;
          if (bitcnt_r == 4'h0)
            armed_r <= 1'b0;
          if (bitcnt_r == ACK_SLOT - 4'h1)
          begin
            case (phase_r)
              PH_SEL:
              begin
                sda_oe_r <= sel_match;
                if (!sel_match)
                  phase_r <= PH_IDLE;
              end
              PH_AHI, PH_ALO: sda_oe_r <= 1'b1;
              PH_WR: sda_oe_r <= ~wp_seen_r;
              default: sda_oe_r <= 1'b0;
            endcase
          end
          else if (bitcnt_r == ACK_SLOT)
          begin
            sda_oe_r <= 1'b0;
            case (phase_r)
              PH_SEL:
              begin
                if (shift_r[0])
                begin
                  phase_r <= PH_RD;
                  out_r <= rd_byte;
                  sda_oe_r <= ~rd_byte[7];
                end
                else
                  phase_r <= PH_AHI;
              end
              PH_AHI:
              begin
                addr_r[ADDR_W-1:8] <= shift_r[ADDR_W-9:0];
                phase_r <= PH_ALO;
              end
              PH_ALO:
              begin
                addr_r[7:0] <= shift_r;
                phase_r <= PH_WR;
              end
              PH_WR:
              begin
                if (!wp_seen_r)
                begin
                  armed_r <= 1'b1;
                  // counter is left on the byte after the last one written
                  addr_r[PAGE_W-1:0] <= addr_r[PAGE_W-1:0] + 1'b1;
                end
              end
              PH_RD:
              begin
                out_r <= rd_byte;
                sda_oe_r <= ~rd_byte[7];
              end
              default: sda_oe_r <= 1'b0;
            endcase
          end
          else if (phase_r == PH_RD)
            sda_oe_r <= ~out_r[3'(6 - bitcnt_r)];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write cycle timer and status
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      busy_cnt_r <= 32'h0;
      busy_r <= 1'b0;
      sda_o_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      busy_cnt_r <= (phase_r == PH_BUSY) ? busy_cnt_r + 32'h1 : 32'h0;
      busy_r <= (phase_r == PH_BUSY);
      sda_o_r <= 1'b0;
    end
  end

  assign {SDA_O, SDA_OE, WRITE_BUSY} = {sda_o_r, sda_oe_r, busy_r};

  ////////////////////////////////////////////////////////////////////////////
  // page buffer: bytes collect here and reach the array only in the cycle
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      pval_r <= '0;
      row_r <= '0;
    end
    else if (CLK_EN)
    begin
      if (phase_r == PH_BUSY && busy_cnt_r == WRITE_CYCLE_TIME - 1)
        pval_r <= '0;
      else if (start_ev && phase_r == PH_IDLE)
        pval_r <= '0;
      else if (phase_r == PH_WR && scl_fall && bitcnt_r == ACK_SLOT - 4'h1 && !wp_seen_r)
      begin
        pval_r[addr_r[PAGE_W-1:0]] <= 1'b1;
        row_r <= addr_r[ADDR_W-1:PAGE_W];
      end
    end
  end

  always_ff @(posedge CORE_CLK)
    if (CLK_EN && phase_r == PH_WR && scl_fall && bitcnt_r == ACK_SLOT - 4'h1 && !wp_seen_r)
      pbuf_r[addr_r[PAGE_W-1:0]] <= shift_r;

  // one word per clock at the start of the cycle; the cycle must span the row
  assign commit_en = (phase_r == PH_BUSY) && (busy_cnt_r < ROW_WORDS);
  assign wi = busy_cnt_r[WI_W-1:0];
  assign waddr = {row_r, wi};
  assign old_word = ecc_fix(mem[waddr]);

  for (genvar b = 0; b < WORD_BYTES; b++)
  begin : g_merge
    assign wval[b] = pval_r[{wi, 2'(b)}];
    assign merged[8*b +: 8] = wval[b] ? pbuf_r[{wi, 2'(b)}] : old_word[8*b +: 8];
  end

  // even a single byte rewrites its whole word and check bits
  always_ff @(posedge CORE_CLK)
    if (CLK_EN && commit_en && (|wval))
      mem[waddr] <= {ecc_calc(merged), merged};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_busy_quiet: assert property (phase_r == PH_BUSY |-> !sda_oe_r)
    else $error("driver active during write cycle");
  a_start_select: assert property (CLK_EN && start_ev && phase_r != PH_BUSY
    |=> phase_r == PH_SEL) else $error("start not taken");
  a_stop_idle: assert property (CLK_EN && stop_ev && phase_r != PH_BUSY
    && !(armed_r && bitcnt_r == 4'h0) |=> phase_r == PH_IDLE) else $error("stop not idle");
  a_stop_write: assert property (CLK_EN && stop_ev && phase_r != PH_BUSY
    && armed_r && bitcnt_r == 4'h0 |=> phase_r == PH_BUSY) else $error("write not started");
  a_sel_mismatch: assert property (CLK_EN && scl_fall && phase_r == PH_SEL
    && bitcnt_r == 4'h7 && !sel_match |=> !sda_oe_r && phase_r == PH_IDLE)
    else $error("mismatch acked");
  a_wp_nack: assert property (CLK_EN && scl_fall && phase_r == PH_WR
    && bitcnt_r == 4'h7 && wp_seen_r |=> !sda_oe_r ##0 bitcnt_r == ACK_SLOT)
    else $error("protected data acked");
  a_addr_ack: assert property (CLK_EN && scl_fall && bitcnt_r == 4'h7
    && (phase_r == PH_AHI || phase_r == PH_ALO) |=> sda_oe_r) else $error("address not acked");
  a_read_nack: assert property (CLK_EN && scl_rise && phase_r == PH_RD
    && bitcnt_r == ACK_SLOT && sda_cap_r |=> phase_r == PH_IDLE) else $error("read kept on");
  a_read_advance: assert property (CLK_EN && scl_rise && phase_r == PH_RD
    && bitcnt_r == ACK_SLOT |=> addr_r == ADDR_W'($past(addr_r) + 1'b1))
    else $error("counter not advanced");
  a_page_wrap: assert property (CLK_EN && scl_fall && phase_r == PH_WR
    && bitcnt_r == ACK_SLOT |=> addr_r[ADDR_W-1:PAGE_W] == $past(addr_r[ADDR_W-1:PAGE_W]))
    else $error("row bits changed");
  a_busy_length: assert property ($fell(busy_r)
    |-> $past(busy_cnt_r, 2) == WRITE_CYCLE_TIME - 1) else $error("wrong write time");

  c_write_cycle: cover property (phase_r != PH_BUSY ##1 phase_r == PH_BUSY);
  c_read_end: cover property (phase_r == PH_RD ##1 phase_r == PH_IDLE);
  c_poll_busy: cover property (phase_r == PH_BUSY && start_ev);
  c_seq_read: cover property (CLK_EN && scl_rise && phase_r == PH_RD
    && bitcnt_r == ACK_SLOT && !sda_cap_r);

endmodule : i2c_serial_eeprom_slave

`default_nettype wire

// File: tb/i2c_master_model.sv
// behavioural two-wire bus master: start, stop and byte transfers
// assumes the bench resolves sda from all pull-downs with a pull-up
`timescale 1ns/100ps
`default_nettype none

module i2c_master_model #(
  parameter int HALF_NS = 100
)(
  // bus
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sda moves mid-way through scl low; scl stands high between frames
  task automatic put(input logic b);
    #(HALF_NS / 2) sda_pull = ~b;
    #(HALF_NS / 2) scl = 1'b1;
    #(HALF_NS) scl = 1'b0;
  endtask : put

  task automatic get(output logic b);
    #(HALF_NS / 2) sda_pull = 1'b0;
    #(HALF_NS / 2) scl = 1'b1;
    b = sda;
    #(HALF_NS) scl = 1'b0;
  endtask : get

  // also serves as repeated start
  task automatic start();
    #(HALF_NS / 2) sda_pull = 1'b0;
    #(HALF_NS / 2) scl = 1'b1;
    #(HALF_NS) sda_pull = 1'b1;
    #(HALF_NS) scl = 1'b0;
  endtask : start

  task automatic stop();
    #(HALF_NS / 2) sda_pull = 1'b1;
    #(HALF_NS / 2) scl = 1'b1;
    #(HALF_NS) sda_pull = 1'b0;
    #(HALF_NS);
  endtask : stop

  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      put(d[i]);
    get(ack);
  endtask : send

  task automatic recv(input logic mack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      get(d[i]);
    put(mack);
  endtask : recv
endmodule : i2c_master_model
`default_nettype wire

// File: tb/i2c_serial_eeprom_slave_tb_top.sv
// self-checking bench for the serial eeprom slave
// assumes the master model as bus partner and a pulled-up sda wire
`timescale 1ns/100ps
`default_nettype none

module i2c_serial_eeprom_slave_tb_top;
  import eeprom_pkg::*;
  // type code value is arbitrary
  localparam logic [3:0] TYPE_ID = 4'h9;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic [2:0] straps = 3'h5;
  wire logic scl;
  wire logic sda_pull;
  wire logic sda;
  logic sda_o;
  logic sda_oe;
  logic busy;
  int mismatches = 0;
  int comparisons = 0;

  always #5 core_clk = ~core_clk;
  assign sda = ~((sda_oe & ~sda_o) | sda_pull);

  i2c_master_model i_mst (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  // short write cycle so that polling still sees it busy
  i2c_serial_eeprom_slave #(.WRITE_CYCLE_TIME(400), .DEV_TYPE_ID(TYPE_ID)) i_dut (
    .CORE_CLK(core_clk), .RST(rst), .CLK_EN(1'b1), .SCL_CLK(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .CHIP_SEL_IN0(straps[0]), .CHIP_SEL_IN1(straps[1]),
    .CHIP_SEL_IN2(straps[2]), .WRITE_PROTECT_IN(wp), .WRITE_BUSY(busy));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic exp, input logic got);
    chk_byte({7'h00, exp}, {7'h00, got});
  endtask : chk_bit

  task automatic sel(input logic [2:0] c, input logic rw, output logic ack);
    i_mst.start();
    i_mst.send({TYPE_ID, c, rw}, ack);
  endtask : sel

  task automatic addr(input logic [15:0] a);
    logic ack;
    sel(straps, 1'b0, ack);
    chk_bit(1'b0, ack);
    i_mst.send(a[15:8], ack);
    chk_bit(1'b0, ack);
    i_mst.send(a[7:0], ack);
    chk_bit(1'b0, ack);
  endtask : addr

  // dack is the acknowledge expected on each data byte
  task automatic wr(input logic [15:0] a, input logic [7:0] d[$], input logic dack);
    logic ack;
    addr(a);
    foreach (d[i])
    begin
      i_mst.send(d[i], ack);
      chk_bit(dack, ack);
    end
    i_mst.stop();
    repeat (5) @(posedge core_clk);
    chk_bit(~dack, busy);
    if (dack == 1'b0)
    begin
      sel(straps, 1'b0, ack);
      chk_bit(1'b1, ack);
      i_mst.stop();
      for (int n = 0; n < 20 && ack !== 1'b0; n++)
      begin
        sel(straps, 1'b0, ack);
        i_mst.stop();
      end
      chk_bit(1'b0, ack);
      chk_bit(1'b0, busy);
      if (ack !== 1'b0)
        end_sim();
    end
  endtask : wr

  // random read from a when rnd is set, else current read; master nacks the last byte
  task automatic rd(input logic rnd, input logic [15:0] a, input logic [7:0] e[$]);
    logic ack;
    logic [7:0] d;
    if (rnd)
      addr(a);
    sel(straps, 1'b1, ack);
    chk_bit(1'b0, ack);
    foreach (e[i])
    begin
      i_mst.recv(i == e.size() - 1, d);
      chk_byte(e[i], d);
    end
    i_mst.stop();
    chk_bit(1'b0, sda_oe);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // second write wraps inside the row and overwrites the first byte
  task automatic sc_page();
    wr(16'h1200, '{8'h11, 8'h22}, 1'b0);
    wr(16'h127f, '{8'h33, 8'h44}, 1'b0);
    rd(1'b0, 16'h0000, '{8'h22});
    rd(1'b1, 16'h127f, '{8'h33});
    rd(1'b1, 16'h1200, '{8'h44, 8'h22});
  endtask : sc_page

  task automatic sc_wrap();
    wr(16'hffff, '{8'h5a}, 1'b0);
    wr(16'h0000, '{8'ha5}, 1'b0);
    rd(1'b1, 16'hffff, '{8'h5a, 8'ha5});
  endtask : sc_wrap

  task automatic sc_protect();
    @(posedge core_clk) #1 wp = 1'b1;
    wr(16'h1200, '{8'h99, 8'h98}, 1'b1);
    rd(1'b1, 16'h1200, '{8'h44});
    @(posedge core_clk) #1 wp = 1'b0;
  endtask : sc_protect

  task automatic sc_addr_stop();
    addr(16'h1201);
    i_mst.stop();
    repeat (5) @(posedge core_clk);
    chk_bit(1'b0, busy);
    rd(1'b1, 16'h1201, '{8'h22});
  endtask : sc_addr_stop

  task automatic sc_chip();
    logic ack;
    for (int c = 0; c < 8; c++)
    begin
      // write select: a read would leave the slave driving data over the stop
      sel(c[2:0], 1'b0, ack);
      chk_bit(c[2:0] != straps, ack);
      i_mst.stop();
    end
  endtask : sc_chip

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (10) @(posedge core_clk);
    sc_chip();
    sc_page();
    sc_wrap();
    sc_protect();
    sc_addr_stop();
    end_sim();
  end

  // a hang anywhere counts as a failure
  initial
  begin
    #500us;
    mismatches++;
    end_sim();
  end
endmodule : i2c_serial_eeprom_slave_tb_top
`default_nettype wire
